/* File: common/rtc_trim_regs.vh */
// register indexes, field positions, reset values and counts for the trim block
`ifndef RTC_TRIM_REGS_VH
`define RTC_TRIM_REGS_VH

// word indexes; byte address is four times the index
`define IDX_CONTROL 6'h08
`define IDX_TRIM 6'h09
`define IDX_OSC_CFG 6'h0a
`define IDX_STATUS 6'h0b

// control register fields
`define CTL_GP_OUT 7
`define CTL_SQW_EN 6
`define CTL_EXT_CLK 3
`define CTL_COARSE 2
`define CTL_FREQ_HI 1
`define CTL_FREQ_LO 0
`define CTL_WRITE_MASK 8'hcf
`define CTL_RESET 8'h00

// trim value register
`define TRIM_RESET 8'h00

// oscillator configuration register fields
`define CFG_DIRECTION 0
`define CFG_OSC_START 1
`define CFG_RESET 2'h0

// status register fields
`define STAT_RUNNING 0
`define STAT_SEC_LO 8

// square wave frequency select codes
`define FREQ_1HZ 2'h0
`define FREQ_4K 2'h1
`define FREQ_8K 2'h2
`define FREQ_32K 2'h3

// prescaler bits that give each divided output
`define TAP_1HZ 14
`define TAP_4K 2
`define TAP_8K 1

// prescaler and minute counts
`define PRE_LAST 15'h7fff
`define PRE_ZERO 15'h0000
`define SEC_LAST 6'h3b
`define SEC_ZERO 6'h00
`define STALL_ZERO 9'h000
`define STALL_ONE 9'h001
`define TRIM_ZERO 8'h00

`endif

/* File: design/rtc_trim_prescaler.v */
// oscillator prescaler with per-minute or per-second digital trim correction
`timescale 1ns/10ps
`default_nettype none
`include "rtc_trim_regs.vh"

module rtc_trim_prescaler (
    input wire clk,
    input wire reset_n,
    input wire oscTick,
    input wire coarseTrimEnable,
    input wire trimDirection,
    input wire [7:0] trimStepCount,
    output wire [14:0] preCount,
    output wire [5:0] secondIndex,
    output reg secondTick
);

reg [14:0] preQ;
reg [8:0] stallQ;
reg [5:0] secQ;
wire boundary;
wire [8:0] trimCycles;

////////////////////////////////////////////////////////////////////////////////
// a correction lands when a minute ends, or every second in coarse mode
assign boundary = coarseTrimEnable | (secQ == `SEC_LAST);
// two oscillator cycles per step
assign trimCycles = {trimStepCount, 1'b0};
assign preCount = preQ;
assign secondIndex = secQ;

////////////////////////////////////////////////////////////////////////////////
// adding cycles skips counts so the second ends early; removing them
// stalls the count, which also stretches the divided square waves
always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
        preQ <= `PRE_ZERO;
        stallQ <= `STALL_ZERO;
        secQ <= `SEC_ZERO;
        secondTick <= 1'b0;
    end else begin
        secondTick <= 1'b0;
        if (oscTick) begin
            if (stallQ != `STALL_ZERO) begin
                stallQ <= stallQ - `STALL_ONE;
            end else if (preQ == `PRE_LAST) begin
                secondTick <= 1'b1;
                secQ <= (secQ == `SEC_LAST) ? `SEC_ZERO : secQ + 6'h01;
                // trim value sampled here, at the boundary
                if (boundary && trimStepCount != `TRIM_ZERO) begin
                    if (trimDirection) begin
                        preQ <= {6'h00, trimCycles};
                    end else begin
                        preQ <= `PRE_ZERO;
                        stallQ <= trimCycles;
                    end
                end else begin
                    preQ <= `PRE_ZERO;
                end
            end else begin
                preQ <= preQ + 15'h0001;
            end
        end
    end
end

endmodule // rtc_trim_prescaler

`default_nettype wire

/* File: design/rtc_digital_trim.v */
// real-time clock digital trim block with avalon register access
// Function
// - trim applied once per minute normally
// - direction bit chooses add or remove
// - each step is two oscillator cycles
// - zero step count disables all trimming
// - coarse mode applies trim every second
// - trimming continues on backup supply
// - trim count register, index 0x09, resets zero
// - divided square waves carry the trim
// - coarse mode outputs trimmed 1 Hz
//
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none
`include "rtc_trim_regs.vh"

module rtc_digital_trim (
    input wire clk,
    input wire reset_n,
    input wire [7:0] address,
    input wire read,
    input wire write,
    input wire [3:0] byteenable,
    input wire [31:0] writedata,
    output reg [31:0] readdata,
    output wire waitrequest,
    input wire crystalOscIn,
    input wire externalClockIn,
    input wire onBackupSupply,
    output reg clockOutputPin,
    output reg secondPulse
);

reg [7:0] controlQ;
reg [7:0] trimValueQ;
reg [1:0] oscCfgQ;
reg ackQ;
reg [2:0] syncQ;
reg oscLevelQ;
reg [2:0] backupSyncQ;
reg backupQ;
reg selOut;
wire oscRunning;
wire oscSource;
wire oscTick;
wire levelAgree;
wire regWrite;
wire lowLane;
wire [5:0] wordIndex;
wire wordAligned;
wire [14:0] preCount;
wire [5:0] secondIndex;
wire secondTick;
wire coarseTrimEnable;
wire squareWaveOutputEnable;
wire [1:0] squareWaveFreqSelect;
wire externalClockSelect;
wire oscillatorStart;
wire trimDirection;

////////////////////////////////////////////////////////////////////////////////
// named views of the configuration bits
assign coarseTrimEnable = controlQ[`CTL_COARSE];
assign squareWaveOutputEnable = controlQ[`CTL_SQW_EN];
assign squareWaveFreqSelect = controlQ[`CTL_FREQ_HI:`CTL_FREQ_LO];
assign externalClockSelect = controlQ[`CTL_EXT_CLK];
assign oscillatorStart = oscCfgQ[`CFG_OSC_START];
assign trimDirection = oscCfgQ[`CFG_DIRECTION];
assign oscRunning = oscillatorStart | externalClockSelect;

////////////////////////////////////////////////////////////////////////////////
// source pick happens before the synchroniser so only one path crosses
assign oscSource = externalClockSelect ? externalClockIn : crystalOscIn;

// three-stage synchroniser; the first stage feeds only the second
always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
        syncQ <= 3'h0;
        backupSyncQ <= 3'h0;
    end else begin
        syncQ <= {syncQ[1:0], oscSource};
        backupSyncQ <= {backupSyncQ[1:0], onBackupSupply};
    end
end

assign levelAgree = (syncQ[1] == syncQ[2]);

// filtered levels change only once the last two stages agree
always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
        oscLevelQ <= 1'b0;
        backupQ <= 1'b0;
    end else begin
        if (levelAgree) begin
            oscLevelQ <= syncQ[2];
        end
        if (backupSyncQ[1] == backupSyncQ[2]) begin
            backupQ <= backupSyncQ[2];
        end
    end
end

// one tick per oscillator rising edge while oscRunning; backup supply does not gate it
assign oscTick = levelAgree & syncQ[2] & ~oscLevelQ & oscRunning;

////////////////////////////////////////////////////////////////////////////////
// trimmed prescaler
rtc_trim_prescaler prescaler (
    .clk(clk),
    .reset_n(reset_n),
    .oscTick(oscTick),
    .coarseTrimEnable(coarseTrimEnable),
    .trimDirection(trimDirection),
    .trimStepCount(trimValueQ),
    .preCount(preCount),
    .secondIndex(secondIndex),
    .secondTick(secondTick)
);

////////////////////////////////////////////////////////////////////////////////
// avalon decode: one wait cycle, then the answer on the next edge
assign wordIndex = address[7:2];
assign wordAligned = (address[1:0] == 2'h0);
assign waitrequest = (read | write) & ~ackQ;
assign regWrite = write & ackQ & wordAligned;
assign lowLane = byteenable[0];

always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
        ackQ <= 1'b0;
    end else begin
        // ack drops after each accepted access so back-to-back requests pace
        ackQ <= (read | write) & ~ackQ;
    end
end

////////////////////////////////////////////////////////////////////////////////
// register writes; only the low byte lane carries data
always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
        controlQ <= `CTL_RESET;
        trimValueQ <= `TRIM_RESET;
        oscCfgQ <= `CFG_RESET;
    end else if (regWrite && lowLane) begin
        if (wordIndex == `IDX_CONTROL) begin
            controlQ <= writedata[7:0] & `CTL_WRITE_MASK;
        end else if (wordIndex == `IDX_TRIM) begin
            trimValueQ <= writedata[7:0];
        end else if (wordIndex == `IDX_OSC_CFG) begin
            oscCfgQ <= writedata[1:0];
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// read data; unmapped or unaligned words read as zero
always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
        readdata <= 32'h00000000;
    end else if (read && !ackQ) begin
        readdata <= 32'h00000000;
        if (!wordAligned) begin
            readdata <= 32'h00000000;
        end else if (wordIndex == `IDX_CONTROL) begin
            readdata[7:0] <= controlQ;
        end else if (wordIndex == `IDX_TRIM) begin
            readdata[7:0] <= trimValueQ;
        end else if (wordIndex == `IDX_OSC_CFG) begin
            readdata[1:0] <= oscCfgQ;
        end else if (wordIndex == `IDX_STATUS) begin
            readdata[`STAT_RUNNING] <= oscRunning;
            readdata[`STAT_SEC_LO+5:`STAT_SEC_LO] <= secondIndex;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// clock output selection; divided taps come from the trimmed prescaler
always @* begin
    if (coarseTrimEnable) begin
        selOut = preCount[`TAP_1HZ];
    end else if (squareWaveFreqSelect == `FREQ_1HZ) begin
        selOut = preCount[`TAP_1HZ];
    end else if (squareWaveFreqSelect == `FREQ_4K) begin
        selOut = preCount[`TAP_4K];
    end else if (squareWaveFreqSelect == `FREQ_8K) begin
        selOut = preCount[`TAP_8K];
    end else begin
        // raw oscillator level: trimming never touches this path
        selOut = oscLevelQ;
    end
end

// pin is registered; square wave and general output die on backup power
always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
        clockOutputPin <= 1'b0;
        secondPulse <= 1'b0;
    end else begin
        secondPulse <= secondTick;
        if (backupQ) begin
            clockOutputPin <= 1'b0;
        end else if (squareWaveOutputEnable) begin
            clockOutputPin <= selOut;
        end else begin
            clockOutputPin <= controlQ[`CTL_GP_OUT];
        end
    end
end

endmodule // rtc_digital_trim

`default_nettype wire

/* File: bench/rtc_digital_trim_sva.sv */
// bus timing, read data and second pulse checks for the trim block
`timescale 1ns/10ps
`default_nettype none
module rtc_digital_trim_sva (
    input wire clk,
    input wire reset_n,
    input wire [7:0] address,
    input wire read,
    input wire write,
    input wire [31:0] readdata,
    input wire waitrequest,
    input wire onBackupSupply,
    input wire clockOutputPin,
    input wire secondPulse
);
default clocking dc @(posedge clk); endclocking
default disable iff (!reset_n);
////////////////////////////////////////////////////////////////////////////////
// register bus: exactly one wait state, none while idle
bus_one_wait_a: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("request not answered after one wait");
bus_first_wait_a: assert property ((read || write) && !waitrequest |=> !(read || write) || waitrequest)
    else $error("new request answered without a wait");
idle_no_wait_a: assert property (!(read || write) |-> !waitrequest)
    else $error("wait raised while idle");
// the trim register is 8 bits, status uses bits 13:8 at most
read_upper_zero_a: assert property (read && !waitrequest |=> readdata[31:14] == 18'h0)
    else $error("unused read bits not zero");
unmapped_zero_a: assert property (read && !waitrequest && address == 8'hfc |=> readdata == 32'h0)
    else $error("unmapped read not zero");
////////////////////////////////////////////////////////////////////////////////
// a second spans at least 32258 oscillator ticks, so pulses stand far apart
pulse_single_a: assert property (secondPulse |=> !secondPulse)
    else $error("second pulse longer than one cycle");
pulse_spacing_a: assert property (secondPulse |=> !secondPulse [*8])
    else $error("second pulses too close");
// the pin is dead on backup power while trimming goes on
backup_pin_low_a: assert property (onBackupSupply [*6] |-> !clockOutputPin)
    else $error("clock pin active on backup");
endmodule // rtc_digital_trim_sva
bind rtc_digital_trim rtc_digital_trim_sva i_rtc_digital_trim_sva (.clk(clk), .reset_n(reset_n),
    .address(address), .read(read), .write(write), .readdata(readdata),
    .waitrequest(waitrequest), .onBackupSupply(onBackupSupply),
    .clockOutputPin(clockOutputPin), .secondPulse(secondPulse));
`default_nettype wire

/* File: bench/rtc_digital_trim_tb.sv */
// self-checking bench: trim register access and length of a trimmed second
`timescale 1ns/10ps
`default_nettype none
module rtc_digital_trim_tb;
logic clk = 1'b0, resetN = 1'b0, read = 1'b0, write = 1'b0, osc = 1'b0, backup = 1'b0;
logic [7:0] address = 8'h00;
logic [3:0] be = 4'h0;
logic [31:0] wdata = 32'h0;
wire [31:0] readdata;
wire waitrequest, pin, secondPulse;
integer seed = 61315, n_mismatch = 0, checked = 0, cyc = 0, phase = 0, tick = 0, lastTick = 0;
logic [31:0] rdQ[$];
integer secQ[$];
integer perQ[$], riseQ[$];
integer lastRise = 0, err = 0;
logic pinPrev = 1'b0;
logic [7:0] n;
logic dir;
initial forever #50 clk = ~clk;
rtc_digital_trim i_rtc_digital_trim (.clk(clk), .reset_n(resetN), .address(address),
    .read(read), .write(write), .byteenable(be), .writedata(wdata), .readdata(readdata),
    .waitrequest(waitrequest), .crystalOscIn(osc), .externalClockIn(osc),
    .onBackupSupply(backup), .clockOutputPin(pin), .secondPulse(secondPulse));
////////////////////////////////////////////////////////////////////////////////
task close_out;
    $display("mismatches=%0d checks=%0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
endtask
task cmp(input logic [31:0] e, input logic [31:0] g);
    checked = checked + 1;
    if (g !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("FAIL t=%0t exp=%h got=%h", $time, e, g);
    end
endtask
task cmpSec(input integer e, input integer g);
    checked = checked + 1;
    if (g !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("FAIL t=%0t exp=%h got=%h", $time, e, g);
    end
endtask
// avalon master: hold everything until waitrequest is sampled low
task bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
    @(posedge clk);
    address <= a;
    wdata <= d;
    be <= b;
    read <= !wr;
    write <= wr;
    do @(posedge clk); while (waitrequest !== 1'b0);
    read <= 1'b0;
    write <= 1'b0;
endtask
task rd(input logic [7:0] a, input logic [31:0] e);
    rdQ.push_back(e);
    bus(1'b0, a, 32'h0, 4'h0);
endtask
// pick an output tap, let old-mode edges pass, then note the rise spacing in ticks
task tapCheck(input logic [7:0] c, input integer e);
    bus(1'b1, 8'h20, {24'h0, c}, 4'h1);
    repeat (120) @(posedge clk);
    perQ.push_back(e);
    while (perQ.size() > 0) @(posedge clk);
endtask
////////////////////////////////////////////////////////////////////////////////
// oscillator of six clocks a period, rising-edge count and hang limit;
// an untrimmed and a trimmed second at six clocks a tick need about 400000 cycles
always @(posedge clk) begin
    cyc <= cyc + 1;
    phase <= (phase == 5) ? 0 : phase + 1;
    osc <= (phase < 3);
    if (phase == 0) tick <= tick + 1;
    if (cyc == 500000) begin
        n_mismatch = n_mismatch + 1;
        close_out;
    end
end
// read data are taken at the edge that sees waitrequest low
always @(posedge clk) begin
    if (read === 1'b1 && waitrequest === 1'b0) begin
        cmp(rdQ.pop_front(), readdata);
    end
end
// pin rises: tick spacing from the previous rise, in the tap under test
always @(posedge clk) begin
    pinPrev <= pin;
    if (pin === 1'b1 && pinPrev === 1'b0) begin
        if (perQ.size() > 0) cmpSec(perQ.pop_front(), tick - lastRise);
        lastRise <= tick;
    end
end
// fixed sync latency cancels when pulse-to-pulse tick counts are taken
always @(posedge clk) begin
    if (secondPulse === 1'b1) begin
        if (secQ.size() > 0) cmpSec(secQ.pop_front(), tick - lastTick);
        if (riseQ.size() > 0) cmpSec(riseQ.pop_front(), tick - lastRise);
        lastTick <= tick;
    end
end
////////////////////////////////////////////////////////////////////////////////
initial begin
    repeat (6) @(posedge clk);
    resetN <= 1'b1;
    rd(8'h24, 32'h0);
    // signed error steps: negative means a fast oscillator
    err = $random(seed) % 256;
    dir = (err > 0);
    n = (err < 0) ? 8'(-err) : 8'(err);
    bus(1'b1, 8'h24, {24'h0, n}, 4'h1);
    bus(1'b1, 8'h24, 32'hff, 4'h0);
    rd(8'h24, {24'h0, n});
    rd(8'hfc, 32'h0);
    bus(1'b1, 8'h28, {30'h0, 1'b1, dir}, 4'h1);
    rd(8'h2c, 32'h1);
    // untrimmed taps early in the first second: 8.192k, 4.096k, raw
    tapCheck(8'h42, 4);
    tapCheck(8'h41, 8);
    tapCheck(8'h43, 1);
    bus(1'b1, 8'h20, 32'hff, 4'h1);
    rd(8'h20, 32'hcf);
    bus(1'b1, 8'h20, 32'h44, 4'h1);
    rd(8'h20, 32'h44);
    // coarse 1 Hz pin rises half a second before the first pulse
    riseQ.push_back(16384);
    @(posedge secondPulse);
    repeat (2) @(posedge clk);
    backup <= 1'b1;
    secQ.push_back(dir ? 32768 - 2 * n : 32768 + 2 * n);
    while (secQ.size() > 0) @(posedge clk);
    backup <= 1'b0;
    repeat (4) @(posedge clk);
    close_out;
end
endmodule // rtc_digital_trim_tb
`default_nettype wire
